// ===== design/rcd_core.sv
// Eight-bit core datapath with two-stage fetch and execute pipeline.
//------------------------------------------------------------
// Summary of operation
//------------------------------------------------------------
//
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/10ps
`include "rcd_defs.svh"
module rcd_core (
  // Clock and reset.
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic MASTER_RESET_N,
  // Mode straps.
  input wire logic RESISTOR_CAP_OSC_MODE,
  input wire logic LARGE_VARIANT,
  // Program memory port.
  output logic [`RCD_PC_W-1:0] PROG_ADDR,
  input wire logic [`RCD_INSN_W-1:0] PROG_DATA,
  // Software register port.
  input wire logic [`RCD_FILE_AW-1:0] REG_ADDR,
  input wire logic [`RCD_DATA_W-1:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [`RCD_DATA_W-1:0] REG_RDATA,
  // Status.
  output logic [`RCD_DATA_W-1:0] WORK_REG,
  output logic [`RCD_DATA_W-1:0] STATUS_REG,
  output logic QUARTER_RATE_OUT
);

  //------------------------------------------------------------
  // Declarations
  //------------------------------------------------------------
  logic [`RCD_DATA_W-1:0] file_r [0:`RCD_REG_FILE_DEPTH-1];
  logic [`RCD_PC_W-1:0] pc_r;
  logic [`RCD_PC_W-1:0] pc_nxt;
  logic [`RCD_INSN_W-1:0] ir_r;
  logic ir_valid_r;
  logic [`RCD_DATA_W-1:0] w_r;
  logic [`RCD_DATA_W-1:0] status_r;
  logic [`RCD_DATA_W-1:0] fsr_r;
  logic [1:0] div_r;
  logic cyc_en;
  logic rst_sync_r;
  logic rst_hold_r;
  logic core_run;
  rcd_pkg::rcd_state_e state_r;
  rcd_pkg::rcd_insn_s insn;
  rcd_pkg::rcd_alu_s alu;
  logic [`RCD_FILE_AW-1:0] eff_addr;
  logic [`RCD_DATA_W-1:0] fval;
  logic [`RCD_DATA_W-1:0] lit;
  logic is_lit;
  logic branch;
  logic wr_file;
  logic wr_w;
  logic wr_flags;
  logic [`RCD_DATA_W-1:0] rdata_r;
  logic [`RCD_PC_W-1:0] pc_mask;

  //------------------------------------------------------------
  // Helper functions
  //------------------------------------------------------------
  // Eight-bit add with carry in; returns result and both carries.
  function automatic rcd_pkg::rcd_alu_s add8(input logic [7:0] a, input logic [7:0] b,
                                             input logic ci);
    logic [4:0] lo;
    logic [4:0] hi;
    rcd_pkg::rcd_alu_s r;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
    r.res = {hi[3:0], lo[3:0]};
    r.c = hi[4];
    r.nb = lo[4];
    r.z = ({hi[3:0], lo[3:0]} == 8'h00);
    return r;
  endfunction : add8

  // Register read with the special locations mapped into the file space.
  function automatic logic [7:0] rd_reg(input logic [6:0] a);
    // The low byte of the counter can be read but is never written here.
    // The indirect location reads as zero when it is named as a pointer target.
    // Status and pointer come from their own registers; every other location but the counter low byte and the indirect one comes straight from the file array.
    case (a)
      `RCD_ADDR_PCL: rd_reg = pc_r[7:0];
      `RCD_ADDR_STATUS: rd_reg = status_r;
      `RCD_ADDR_FSR: rd_reg = fsr_r;
      `RCD_ADDR_INDF: rd_reg = 8'h00;
      default: rd_reg = file_r[a];
    endcase
  endfunction : rd_reg

  // Data operations that choose their destination from the direction bit.
  function automatic logic data_op(input logic [3:0] op);
    return (op <= `RCD_OP_MOVF) && (op != `RCD_OP_MOVWF);
  endfunction : data_op

  // Program flow and idle operations that never write data or flags.
  function automatic logic quiet_op(input logic [3:0] op);
    return op >= `RCD_OP_GOTO;
  endfunction : quiet_op

  //------------------------------------------------------------
  // Reset and cycle timing
  //------------------------------------------------------------
  // The pin reset is sampled, so the core halts while it is low.
  // Two stages keep a slow pin edge from reaching the pipeline in mid-cycle.
  // Release therefore takes two clocks before the cycle divider starts.
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      rst_sync_r <= 1'b0;
      rst_hold_r <= 1'b0;
    end else begin
      rst_sync_r <= MASTER_RESET_N;
      rst_hold_r <= rst_sync_r;
    end
  end
  assign core_run = rst_hold_r;

  // One instruction cycle is four clocks; the enable marks its last.
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      div_r <= 2'h0;
    end else if (!core_run) begin
      div_r <= 2'h0;
    end else begin
      div_r <= div_r + 2'h1;
    end
  end
  assign cyc_en = core_run && (div_r == `RCD_QUARTER_DIV);

  // The output is high for half of each instruction cycle: its last clock and the first clock of the next.
  // It stays low outside oscillator mode and while the core is held.

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      QUARTER_RATE_OUT <= 1'b0;
    end else begin
      QUARTER_RATE_OUT <= RESISTOR_CAP_OSC_MODE && core_run && div_r[1];
    end
  end

  //------------------------------------------------------------
  // Decode and operand selection
  //------------------------------------------------------------
  // The literal is seven bits wide and is zero-extended to a byte.
  // The field doubles as file address, literal and branch target.
  assign insn = rcd_pkg::rcd_insn_s'(ir_r);
  assign lit = {1'b0, insn.fld};
  assign is_lit = (insn.op == `RCD_OP_MOVLW) || (insn.op == `RCD_OP_ADDLW);
  // Location zero reaches the register named by the pointer.
  assign eff_addr = (insn.fld == `RCD_ADDR_INDF) ? fsr_r[6:0] : insn.fld;
  assign fval = rd_reg(eff_addr);
  assign branch = ir_valid_r && (state_r == rcd_pkg::ST_RUN) && (insn.op == `RCD_OP_GOTO);
  assign pc_mask = LARGE_VARIANT ? 11'h7FF : 11'h1FF;

  //------------------------------------------------------------
  // Arithmetic and logic unit
  //------------------------------------------------------------
  always_comb begin
    alu = '{res: 8'h00, c: status_r[`RCD_FLAG_C], nb: status_r[`RCD_FLAG_NB], z: 1'b0};
    wr_file = 1'b0;
    wr_w = 1'b0;
    wr_flags = 1'b0;
    case (insn.op)
      `RCD_OP_MOVWF: begin
        alu.res = w_r;
        wr_file = 1'b1;
      end
      `RCD_OP_ADDWF, `RCD_OP_ADDLW: begin
        alu = add8(w_r, is_lit ? lit : fval, 1'b0);
        wr_flags = 1'b1;
      end
      // Subtraction adds the complement of the working register plus one.
      // Both carries then read as inverted borrows.
      `RCD_OP_SUBWF: begin
        alu = add8(fval, ~w_r, 1'b1);
        wr_flags = 1'b1;
      end
      `RCD_OP_ANDWF: alu.res = w_r & fval;
      `RCD_OP_IORWF: alu.res = w_r | fval;
      `RCD_OP_XORWF: alu.res = w_r ^ fval;
      `RCD_OP_RLF: begin
        alu.res = {fval[6:0], status_r[`RCD_FLAG_C]};
        alu.c = fval[7];
        wr_flags = 1'b1;
      end
      `RCD_OP_RRF: begin
        alu.res = {status_r[`RCD_FLAG_C], fval[7:1]};
        alu.c = fval[0];
        wr_flags = 1'b1;
      end
      `RCD_OP_INCF: alu.res = fval + 8'h01;
      `RCD_OP_DECF: alu.res = fval - 8'h01;
      `RCD_OP_COMF: alu.res = ~fval;
      `RCD_OP_MOVF: alu.res = fval;
      `RCD_OP_MOVLW: alu.res = lit;
      default: alu.res = 8'h00;
    endcase
    alu.z = (alu.res == 8'h00);
    if (data_op(insn.op)) begin
      wr_file = insn.dest_f;
      wr_w = !insn.dest_f;
    end
    // Literal operations always land in the working register.
    if (is_lit) begin
      wr_w = 1'b1;
    end
    // Nothing is written during the idle cycle after a taken branch.
    // The bubble before the first fetch is treated the same way.
    if (!ir_valid_r || state_r != rcd_pkg::ST_RUN || quiet_op(insn.op)) begin
      wr_file = 1'b0;
      wr_w = 1'b0;
      wr_flags = 1'b0;
    end
  end

  //------------------------------------------------------------
  // Fetch pipeline and program flow
  //------------------------------------------------------------
  always_comb begin
    // The counter wraps at the end of the selected memory size.
    pc_nxt = (pc_r + 11'h001) & pc_mask;
    if (branch) begin
      pc_nxt = {4'h0, insn.fld} & pc_mask;
    end
  end

  // Fetch on the program bus while the data side executes.
  // The word fetched with a taken branch is loaded but never executed.
  // During the idle cycle the branch target is fetched, so the target
  // executes in the cycle after it and the branch costs two cycles.
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      pc_r <= 11'h000;
      ir_r <= 12'h000;
      ir_valid_r <= 1'b0;
      state_r <= rcd_pkg::ST_RUN;
    end else if (!core_run) begin
      pc_r <= 11'h000;
      ir_valid_r <= 1'b0;
      state_r <= rcd_pkg::ST_RUN;
    end else if (cyc_en) begin
      pc_r <= pc_nxt;
      ir_r <= PROG_DATA;
      ir_valid_r <= 1'b1;
      case (state_r)
        rcd_pkg::ST_RUN: state_r <= branch ? rcd_pkg::ST_FLUSH : rcd_pkg::ST_RUN;
        rcd_pkg::ST_FLUSH: state_r <= rcd_pkg::ST_RUN;
        default: state_r <= rcd_pkg::ST_RUN;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      PROG_ADDR <= 11'h000;
    end else if (!core_run) begin
      PROG_ADDR <= 11'h000;
    end else if (cyc_en) begin
      PROG_ADDR <= pc_nxt;
    end
  end

  //------------------------------------------------------------
  // Working register and flags
  //------------------------------------------------------------
  // The core's own flag update wins over a port write in the same cycle.
  // A port write to the status location lands only when no instruction
  // writes back at that edge.
  // The working register is cleared while the device reset holds the core.
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      w_r <= 8'h00;
    end else if (!core_run) begin
      w_r <= 8'h00;
    end else if (cyc_en && wr_w) begin
      w_r <= alu.res;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      status_r <= `RCD_STATUS_RST;
    end else if (!core_run) begin
      status_r <= `RCD_STATUS_RST;
    end else if (cyc_en && (wr_flags || wr_file || wr_w)) begin
      if (wr_file && eff_addr == `RCD_ADDR_STATUS) begin
        status_r <= alu.res;
      end
      if (wr_flags) begin
        status_r[`RCD_FLAG_C] <= alu.c;
        status_r[`RCD_FLAG_NB] <= alu.nb;
      end
      status_r[`RCD_FLAG_Z] <= alu.z;
    end else if (REG_WR && REG_ADDR == `RCD_ADDR_STATUS) begin
      status_r <= REG_WDATA;
    end
  end

  //------------------------------------------------------------
  // Register file and pointer
  //------------------------------------------------------------
  // The core's own write wins over a port write in the same cycle.
  // A refused port write is lost; software should read back to confirm.
  // The file itself is not cleared by either reset.
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      fsr_r <= 8'h00;
    end else if (cyc_en && wr_file && eff_addr == `RCD_ADDR_FSR) begin
      fsr_r <= alu.res;
    end else if (REG_WR && REG_ADDR == `RCD_ADDR_FSR) begin
      fsr_r <= REG_WDATA;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (cyc_en && wr_file) begin
      file_r[eff_addr] <= alu.res;
    end else if (REG_WR) begin
      file_r[REG_ADDR] <= REG_WDATA;
    end
  end

  //------------------------------------------------------------
  // Register read port and outputs
  //------------------------------------------------------------
  // Read data stand for the one cycle after the strobe and are zero otherwise.
  // The status outputs are copies one clock behind the live registers.
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      rdata_r <= 8'h00;
    end else if (REG_RD) begin
      rdata_r <= rd_reg(REG_ADDR);
    end else begin
      rdata_r <= 8'h00;
    end
  end
  assign REG_RDATA = rdata_r;

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      WORK_REG <= 8'h00;
      STATUS_REG <= `RCD_STATUS_RST;
    end else begin
      WORK_REG <= w_r;
      STATUS_REG <= status_r;
    end
  end

endmodule : rcd_core

// ===== design/rcd_defs.svh
// Constants for the eight-bit core datapath.
`ifndef RCD_DEFS_SVH
`define RCD_DEFS_SVH
`define RCD_INSN_W 12
`define RCD_DATA_W 8
`define RCD_PC_W_SMALL 9
`define RCD_PC_W_LARGE 11
`define RCD_PC_W 11
`define RCD_FILE_AW 7
`define RCD_REG_FILE_DEPTH 128
`define RCD_ADDR_INDF 7'h00
`define RCD_ADDR_PCL 7'h02
`define RCD_ADDR_STATUS 7'h03
`define RCD_ADDR_FSR 7'h04
`define RCD_FLAG_C 0
`define RCD_FLAG_NB 1
`define RCD_FLAG_Z 2
`define RCD_STATUS_RST 8'h18
`define RCD_QUARTER_DIV 2'h3
`define RCD_OP_MOVWF 4'h0
`define RCD_OP_ADDWF 4'h1
`define RCD_OP_SUBWF 4'h2
`define RCD_OP_ANDWF 4'h3
`define RCD_OP_IORWF 4'h4
`define RCD_OP_XORWF 4'h5
`define RCD_OP_RLF 4'h6
`define RCD_OP_RRF 4'h7
`define RCD_OP_INCF 4'h8
`define RCD_OP_DECF 4'h9
`define RCD_OP_COMF 4'hA
`define RCD_OP_MOVF 4'hB
`define RCD_OP_MOVLW 4'hC
`define RCD_OP_ADDLW 4'hD
`define RCD_OP_GOTO 4'hE
`define RCD_OP_NOP 4'hF
`endif

// ===== design/rcd_pkg.sv
// Types used by the core datapath; its bench does not use them.
package rcd_pkg;
  typedef enum logic [1:0] {ST_RUN, ST_FLUSH} rcd_state_e;
  typedef struct packed {
    logic [3:0] op;
    logic dest_f;
    logic [6:0] fld;
  } rcd_insn_s;
  typedef struct packed {
    logic [7:0] res;
    logic c;
    logic nb;
    logic z;
  } rcd_alu_s;
endpackage : rcd_pkg

// ===== tb/rcd_core_properties.sv
// Concurrent checks on the core datapath ports.
`timescale 1ns/10ps
`include "rcd_defs.svh"
module rcd_core_properties (
  // Clock and reset.
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic MASTER_RESET_N,
  // Mode straps.
  input wire logic RESISTOR_CAP_OSC_MODE,
  input wire logic LARGE_VARIANT,
  // Program memory port.
  input wire logic [`RCD_PC_W-1:0] PROG_ADDR,
  input wire logic [`RCD_INSN_W-1:0] PROG_DATA,
  // Software register port.
  input wire logic [`RCD_FILE_AW-1:0] REG_ADDR,
  input wire logic [`RCD_DATA_W-1:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [`RCD_DATA_W-1:0] REG_RDATA,
  // Status.
  input wire logic [`RCD_DATA_W-1:0] WORK_REG,
  input wire logic [`RCD_DATA_W-1:0] STATUS_REG,
  input wire logic QUARTER_RATE_OUT
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  sequence s_wr_rd;
    $past(REG_WR) && REG_RD && ($past(REG_ADDR) == REG_ADDR) && (REG_ADDR[6:5] != 2'h0);
  endsequence
  sequence s_quarter;
    QUARTER_RATE_OUT ##1 !QUARTER_RATE_OUT [*2] ##1 QUARTER_RATE_OUT;
  endsequence
  property p_fetch_step;
    disable iff (!RST_N || !MASTER_RESET_N) $changed(PROG_ADDR) |=> $stable(PROG_ADDR) [*3];
  endproperty
  property p_small_pc;
    !LARGE_VARIANT && !$past(LARGE_VARIANT) |-> PROG_ADDR < 11'h200;
  endproperty
  property p_wr_rd;
    s_wr_rd |=> REG_RDATA == $past(REG_WDATA, 2);
  endproperty
  property p_rdata_idle;
    !$past(REG_RD) |-> REG_RDATA == 8'h00;
  endproperty
  property p_status_rst;
    $rose(RST_N) |-> STATUS_REG == `RCD_STATUS_RST && WORK_REG == 8'h00;
  endproperty
  property p_master_hold;
    (!MASTER_RESET_N) [*6] |-> PROG_ADDR == 11'h000 && STATUS_REG == `RCD_STATUS_RST;
  endproperty
  property p_quarter_shape;
    disable iff (!RST_N || !MASTER_RESET_N) $rose(QUARTER_RATE_OUT) |=> s_quarter;
  endproperty
  property p_quarter_off;
    !RESISTOR_CAP_OSC_MODE |-> !QUARTER_RATE_OUT;
  endproperty
  a_fetch_step: assert property (p_fetch_step) else $error("fetch step not four clocks");
  a_small_pc: assert property (p_small_pc) else $error("address beyond small memory");
  a_wr_rd: assert property (p_wr_rd) else $error("file readback differs");
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");
  a_status_rst: assert property (p_status_rst) else $error("bad reset values");
  a_master_hold: assert property (p_master_hold) else $error("core not held in reset");
  a_quarter_shape: assert property (p_quarter_shape) else $error("quarter output shape");
  a_quarter_off: assert property (p_quarter_off) else $error("quarter output when off");
endmodule : rcd_core_properties

bind rcd_core rcd_core_properties u_props (.CLK_SYS, .RST_N, .MASTER_RESET_N,
  .RESISTOR_CAP_OSC_MODE, .LARGE_VARIANT, .PROG_ADDR, .PROG_DATA, .REG_ADDR, .REG_WDATA,
  .REG_WR, .REG_RD, .REG_RDATA, .WORK_REG, .STATUS_REG, .QUARTER_RATE_OUT);

// ===== tb/rcd_prog_mem.sv
// Program memory model answering fetches of the core.
`timescale 1ns/10ps
`include "rcd_defs.svh"
module rcd_prog_mem (
  // Fetch port.
  input wire logic [`RCD_PC_W-1:0] PROG_ADDR,
  output logic [`RCD_INSN_W-1:0] PROG_DATA
);
  logic [`RCD_INSN_W-1:0] rom [0:2047];
  // The word follows the address at once so it is settled at the fetch edge.
  assign PROG_DATA = rom[PROG_ADDR];
endmodule : rcd_prog_mem

// ===== tb/tb_rcd_core.sv
// Self-checking bench for the core datapath.
`timescale 1ns/10ps
`include "rcd_defs.svh"
module tb_rcd_core;
  logic CLK_SYS, RST_N, MASTER_RESET_N, RESISTOR_CAP_OSC_MODE, LARGE_VARIANT;
  logic REG_WR, REG_RD, QUARTER_RATE_OUT, rd_d;
  logic [`RCD_PC_W-1:0] PROG_ADDR;
  logic [`RCD_INSN_W-1:0] PROG_DATA;
  logic [`RCD_FILE_AW-1:0] REG_ADDR;
  logic [`RCD_DATA_W-1:0] REG_WDATA, REG_RDATA, WORK_REG, STATUS_REG, exp_v;
  logic [`RCD_DATA_W-1:0] exp_q [$];
  int mismatches, checked, n;
  rcd_core DUT (.CLK_SYS, .RST_N, .MASTER_RESET_N, .RESISTOR_CAP_OSC_MODE, .LARGE_VARIANT,
    .PROG_ADDR, .PROG_DATA, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .WORK_REG,
    .STATUS_REG, .QUARTER_RATE_OUT);
  rcd_prog_mem mem (.PROG_ADDR, .PROG_DATA);
  initial begin
    CLK_SYS = 1'b0;
    forever #5 CLK_SYS = ~CLK_SYS;
  end
  task automatic chk(input string what, input logic [10:0] e, input logic [10:0] s);
    checked++;
    if (e !== s) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, s);
    end
  endtask : chk
  task automatic complete_run;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  task automatic bus(input logic w, input logic r, input logic [6:0] a, input logic [7:0] d);
    REG_WR <= w;
    REG_RD <= r;
    REG_ADDR <= a;
    REG_WDATA <= d;
    if (r) exp_q.push_back(d);
    @(posedge CLK_SYS);
  endtask : bus
  task automatic wait_pc(input logic [10:0] a);
    n = 0;
    #1;
    while (PROG_ADDR !== a) begin
      @(posedge CLK_SYS);
      #1;
      n++;
      if (n > 400) begin
        mismatches++;
        complete_run();
      end
    end
  endtask : wait_pc
  // Answers are compared in the cycle after each read strobe.
  always @(posedge CLK_SYS) begin
    if (rd_d === 1'b1) begin
      exp_v = exp_q.pop_front();
      chk("REG_RDATA", exp_v, REG_RDATA);
    end
    rd_d <= REG_RD;
  end
  task automatic run_prog(input string name);
    logic [6:0] a;
    logic [7:0] d;
    logic [7:0] cnt;
    wait_pc(11'h008);
    repeat (12) @(posedge CLK_SYS);
    #1;
    chk("WORK_REG", 11'h005, WORK_REG);
    chk("STATUS_REG", 11'h000, STATUS_REG & 8'h05);
    @(posedge CLK_SYS);
    bus(1'b0, 1'b1, 7'h10, 8'h05);
    bus(1'b0, 1'b1, `RCD_ADDR_FSR, 8'h10);
    a = 7'h20 | 7'($urandom_range(95));
    d = 8'($urandom);
    bus(1'b1, 1'b0, a, d);
    bus(1'b0, 1'b1, a, d);
    bus(1'b0, 1'b0, a, d);
    chk("WORK_REG", 11'h005, WORK_REG);
    wait_pc(11'h009);
    repeat (4) @(posedge CLK_SYS);
    #1;
    chk("PROG_ADDR", 11'h008, PROG_ADDR);
    repeat (4) @(posedge CLK_SYS);
    #1;
    chk("PROG_ADDR", 11'h009, PROG_ADDR);
    cnt = 8'h00;
    repeat (40) begin
      @(posedge CLK_SYS);
      #1;
      cnt = cnt + {7'h00, QUARTER_RATE_OUT};
    end
    chk("QUARTER_RATE_OUT", RESISTOR_CAP_OSC_MODE ? 11'd20 : 11'd0, cnt);
    $display("test %s done", name);
  endtask : run_prog
  initial begin
    RST_N = 1'b0;
    MASTER_RESET_N = 1'b1;
    RESISTOR_CAP_OSC_MODE = 1'b1;
    LARGE_VARIANT = 1'b0;
    REG_WR = 1'b0;
    REG_RD = 1'b0;
    REG_ADDR = 7'h00;
    REG_WDATA = 8'h00;
    rd_d = 1'b0;
    mismatches = 0;
    checked = 0;
    void'($urandom(32'h9DD51AA9));
    for (n = 0; n < 2048; n++) mem.rom[n] = {`RCD_OP_NOP, 8'h00};
    mem.rom[0] = {`RCD_OP_MOVLW, 8'h05};
    mem.rom[1] = {`RCD_OP_MOVWF, 1'b1, 7'h10};
    mem.rom[2] = {`RCD_OP_MOVLW, 8'h03};
    mem.rom[3] = {`RCD_OP_SUBWF, 1'b1, 7'h10};
    mem.rom[4] = {`RCD_OP_RLF, 1'b1, 7'h10};
    mem.rom[5] = {`RCD_OP_MOVLW, 8'h10};
    mem.rom[6] = {`RCD_OP_MOVWF, 1'b1, `RCD_ADDR_FSR};
    mem.rom[7] = {`RCD_OP_MOVF, 1'b0, `RCD_ADDR_INDF};
    mem.rom[8] = {`RCD_OP_GOTO, 8'h08};
    repeat (16) @(posedge CLK_SYS);
    RST_N <= 1'b1;
    run_prog("first run");
    MASTER_RESET_N <= 1'b0;
    repeat (8) @(posedge CLK_SYS);
    #1;
    chk("PROG_ADDR", 11'h000, PROG_ADDR);
    chk("STATUS_REG", 11'h018, STATUS_REG);
    @(posedge CLK_SYS);
    MASTER_RESET_N <= 1'b1;
    run_prog("device reset");
    RST_N <= 1'b0;
    RESISTOR_CAP_OSC_MODE <= 1'b0;
    LARGE_VARIANT <= 1'b1;
    repeat (4) @(posedge CLK_SYS);
    #1;
    chk("STATUS_REG", 11'h018, STATUS_REG);
    @(posedge CLK_SYS);
    RST_N <= 1'b1;
    run_prog("large variant");
    complete_run();
  end
endmodule : tb_rcd_core
